// [logic/cpt_pkg.sv]
// Package: constants and types for the card parameter transfer controller
package cpt_pkg;
    // Register byte addresses (each register one aligned word)
    localparam logic [7:0] CPT_ADDR_COMMISSION  = 8'h00;
    localparam logic [7:0] CPT_ADDR_UPLOAD      = 8'h04;
    localparam logic [7:0] CPT_ADDR_DOWNLOAD    = 8'h08;
    localparam logic [7:0] CPT_ADDR_CLONE_INDEX = 8'h0c;
    localparam logic [7:0] CPT_ADDR_AUTO_POLICY = 8'h10;
    localparam logic [7:0] CPT_ADDR_REJECTED    = 8'h14;
    localparam logic [7:0] CPT_ADDR_STATUS      = 8'h18;
    localparam logic [7:0] CPT_ADDR_CLEAR       = 8'h1c;

    // Commissioning selector values
    localparam logic [6:0] CPT_SEL_READY    = 7'h00;
    localparam logic [6:0] CPT_SEL_QUICK    = 7'h01;
    localparam logic [6:0] CPT_SEL_INVERTER = 7'h02;
    localparam logic [6:0] CPT_SEL_TRANSFER = 7'h1e;
    localparam logic [6:0] CPT_SEL_SAFETY   = 7'h5f;

    // Transfer request values
    localparam logic [1:0] CPT_REQ_OFF   = 2'h0;
    localparam logic [1:0] CPT_REQ_PANEL = 2'h1;
    localparam logic [1:0] CPT_REQ_CARD  = 2'h2;

    // Automatic download policy values
    localparam logic [1:0] CPT_AUTO_NEVER = 2'h0;
    localparam logic [1:0] CPT_AUTO_ONCE  = 2'h1;
    localparam logic [1:0] CPT_AUTO_ALWAYS = 2'h2;
    localparam logic [1:0] CPT_AUTO_RESET = CPT_AUTO_ONCE;

    localparam logic [6:0] CPT_CLONE_MAX  = 7'h63;
    localparam logic [6:0] CPT_CLONE_AUTO = 7'h00;

    // Status register bit positions
    localparam int CPT_ST_BUSY       = 0;
    localparam int CPT_ST_READY      = 1;
    localparam int CPT_ST_FAULT_LAMP = 2;
    localparam int CPT_ST_MISSING    = 3;
    localparam int CPT_ST_INVALID    = 4;
    localparam int CPT_ST_INCOMPAT   = 5;
    localparam int CPT_ST_NVM        = 6;
    localparam int CPT_ST_ALARM      = 7;
    localparam int CPT_ST_AUTO_DONE  = 8;
    localparam int CPT_ST_CARD       = 9;

    // Lamp flash half period
    localparam int CPT_FLASH_MS     = 250;
    localparam int CPT_CLK_KHZ      = 50000;
    localparam int CPT_FLASH_CYCLES = CPT_FLASH_MS * CPT_CLK_KHZ;

    // Card / storage operation codes issued to the back end
    typedef enum logic [2:0] {
        CPT_OP_NONE,
        CPT_OP_SAVE_WORKING,
        CPT_OP_WRITE_CARD,
        CPT_OP_READ_CARD,
        CPT_OP_COMMIT,
        CPT_OP_RESTORE
    } cpt_op_t;

    // Back end result codes
    localparam logic [1:0] CPT_RES_OK      = 2'h0;
    localparam logic [1:0] CPT_RES_INVALID = 2'h1;
    localparam logic [1:0] CPT_RES_INCOMPAT = 2'h2;
    localparam logic [1:0] CPT_RES_NVM     = 2'h3;
endpackage : cpt_pkg

// [logic/cpt_card_transfer.sv]
// Card parameter transfer controller with APB register access
//
// Function
// - Selector takes 0,1,2,30,95; transfers need 30
// - Clone index 0..99 picks card file
// - Upload request: 0 off, 1 panel, 2 card
// - Save working set before card upload
// - Upload success clears selector, request; ready
// - Upload failure: missing or storage fault lamp
// - Ready lamp flashes during card upload
// - Fault state: fault lamp on, ready off
// - Download request: 0 off, 1 panel, 2 card
// - Commands ignored during download
// - Download cannot be aborted
// - Failed download restores stored set
// - Incompatible parameter: fault, record first number
// - Download success clears selector, request; ready
// - Download failure reports one of four faults
// - Auto download uses file zero, skipped if absent
// - Auto download loads all parameters incl. fail-safe
// - Policy 0: never auto download; reset reloads policy 1, so the next start-up still auto downloads
// - Policy 1: once, then policy becomes 0; reset reloads 1, so it repeats at each start-up
// - Policy 2: auto download every start-up
// - Card inserted with policy 0 raises alarm
// - Auto download success raises pending message
`timescale 1ns/1ps
module cpt_card_transfer #(
    parameter int FLASH_CYCLES = cpt_pkg::CPT_FLASH_CYCLES
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    input  wire logic                card_present,
    input  wire logic                clone00_present,
    output logic                     op_start,
    output cpt_pkg::cpt_op_t         op_code,
    output logic [6:0]               op_file,
    output logic                     op_all_params,
    input  wire logic                op_done,
    input  wire logic [1:0]          op_result,
    input  wire logic [15:0]         op_rejected_param,
    output logic                     ready_lamp,
    output logic                     fault_lamp,
    output logic                     transfer_busy
);
    import cpt_pkg::*;

    typedef enum logic [3:0] {
        S_STARTUP, S_IDLE, S_UP_SAVE, S_UP_WRITE, S_DN_READ, S_DN_COMMIT,
        S_DN_RESTORE, S_WAIT
    } cpt_state_t;

    typedef struct packed {
        cpt_state_t  state;
        cpt_state_t  after;
        logic        is_auto;
        logic        is_upload;
        logic [6:0]  selector;
        logic [1:0]  upload_req;
        logic [1:0]  download_req;
        logic [6:0]  clone_index;
        logic [1:0]  auto_policy;
        logic [15:0] rejected;
        logic        f_missing;
        logic        f_invalid;
        logic        f_incompat;
        logic        f_nvm;
        logic        alarm;
        logic        auto_done;
        logic        card_seen;
        logic        op_start;
        cpt_op_t     op_code;
        logic [6:0]  op_file;
        logic        op_all;
        logic [1:0]  pend_fault;
        logic        flash;
        logic [31:0] flash_cnt;
        logic [31:0] prdata;
    } cpt_regs_t;

    cpt_regs_t r_r, r_nxt;

    logic        wr_en;
    logic        rd_en;
    logic        fault_any;
    logic        busy;
    logic [31:0] status;

    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;
    assign busy  = (r_r.state != S_IDLE) && (r_r.state != S_STARTUP);
    assign fault_any = r_r.f_missing | r_r.f_invalid | r_r.f_incompat | r_r.f_nvm;

    always_comb begin
        status = 32'h0000_0000;
        status[CPT_ST_BUSY]       = busy;
        status[CPT_ST_READY]      = ready_lamp;
        status[CPT_ST_FAULT_LAMP] = fault_lamp;
        status[CPT_ST_MISSING]    = r_r.f_missing;
        status[CPT_ST_INVALID]    = r_r.f_invalid;
        status[CPT_ST_INCOMPAT]   = r_r.f_incompat;
        status[CPT_ST_NVM]        = r_r.f_nvm;
        status[CPT_ST_ALARM]      = r_r.alarm;
        status[CPT_ST_AUTO_DONE]  = r_r.auto_done;
        status[CPT_ST_CARD]       = card_present;
    end

    // Issue a back-end operation and park in the wait state
    function automatic cpt_regs_t issue(input cpt_regs_t s, input cpt_op_t op,
                                        input cpt_state_t nxt);
        cpt_regs_t t;
        t          = s;
        t.op_start = 1'b1;
        t.op_code  = op;
        t.after    = nxt;
        t.state    = S_WAIT;
        return t;
    endfunction : issue

    always_comb begin
        r_nxt          = r_r;
        r_nxt.op_start = 1'b0;
        r_nxt.card_seen = card_present;

        // Flash timer only runs during card upload
        if (r_r.is_upload && busy) begin
            if (r_r.flash_cnt >= FLASH_CYCLES - 1) begin
                r_nxt.flash_cnt = 32'h0000_0000;
                r_nxt.flash     = ~r_r.flash;
            end else begin
                r_nxt.flash_cnt = r_r.flash_cnt + 32'h0000_0001;
            end
        end else begin
            r_nxt.flash_cnt = 32'h0000_0000;
            r_nxt.flash     = 1'b0;
        end

        // Register writes; ignored while a download runs
        if (wr_en && !(busy && !r_r.is_upload)) begin
            case (paddr)
                CPT_ADDR_COMMISSION: begin
                    if (!busy && (pwdata[6:0] == CPT_SEL_READY ||
                                  pwdata[6:0] == CPT_SEL_QUICK ||
                                  pwdata[6:0] == CPT_SEL_INVERTER ||
                                  pwdata[6:0] == CPT_SEL_TRANSFER ||
                                  pwdata[6:0] == CPT_SEL_SAFETY) && pwdata[31:7] == 25'h0)
                        r_nxt.selector = pwdata[6:0];
                end
                CPT_ADDR_UPLOAD: begin
                    if (!busy && pwdata[31:0] <= 32'h2)
                        r_nxt.upload_req = pwdata[1:0];
                end
                CPT_ADDR_DOWNLOAD: begin
                    if (!busy && pwdata[31:0] <= 32'h2)
                        r_nxt.download_req = pwdata[1:0];
                end
                CPT_ADDR_CLONE_INDEX: begin
                    if (!busy && pwdata[31:0] <= {25'h0, CPT_CLONE_MAX})
                        r_nxt.clone_index = pwdata[6:0];
                end
                CPT_ADDR_AUTO_POLICY: begin
                    if (pwdata[31:0] <= 32'h2)
                        r_nxt.auto_policy = pwdata[1:0];
                end
                CPT_ADDR_CLEAR: begin
                    // Write-one-to-clear; acknowledging the alarm needs nothing more
                    if (pwdata[CPT_ST_MISSING])   r_nxt.f_missing  = 1'b0;
                    if (pwdata[CPT_ST_INVALID])   r_nxt.f_invalid  = 1'b0;
                    if (pwdata[CPT_ST_INCOMPAT])  r_nxt.f_incompat = 1'b0;
                    if (pwdata[CPT_ST_NVM])       r_nxt.f_nvm      = 1'b0;
                    if (pwdata[CPT_ST_ALARM])     r_nxt.alarm      = 1'b0;
                    if (pwdata[CPT_ST_AUTO_DONE]) r_nxt.auto_done  = 1'b0;
                end
                default: ;
            endcase
        end

        // Insertion alarm; set wins over a same-cycle clear
        if (card_present && !r_r.card_seen && r_r.auto_policy == CPT_AUTO_NEVER)
            r_nxt.alarm = 1'b1;

        case (r_r.state)
            S_STARTUP: begin
                // Start-up: policy decides auto download
                if (r_r.auto_policy != CPT_AUTO_NEVER && card_present && clone00_present) begin
                    if (r_r.auto_policy == CPT_AUTO_ONCE)
                        r_nxt.auto_policy = CPT_AUTO_NEVER;
                    r_nxt.is_auto   = 1'b1;
                    r_nxt.is_upload = 1'b0;
                    r_nxt.op_file   = CPT_CLONE_AUTO;
                    r_nxt.op_all    = 1'b1;
                    r_nxt = issue(r_nxt, CPT_OP_READ_CARD, S_DN_READ);
                end else begin
                    r_nxt.state = S_IDLE; // Absent file skips it
                end
            end
            S_IDLE: if (!fault_any) begin // Faults block restarts
                if (r_r.selector == CPT_SEL_TRANSFER && r_r.upload_req == CPT_REQ_CARD) begin
                    r_nxt.is_auto   = 1'b0;
                    r_nxt.is_upload = 1'b1;
                    r_nxt.op_file   = r_r.clone_index;
                    r_nxt.op_all    = 1'b0;
                    r_nxt = issue(r_nxt, CPT_OP_SAVE_WORKING, S_UP_SAVE);
                end else if (r_r.selector == CPT_SEL_TRANSFER &&
                             r_r.download_req == CPT_REQ_CARD) begin
                    r_nxt.is_auto   = 1'b0;
                    r_nxt.is_upload = 1'b0;
                    r_nxt.op_file   = r_r.clone_index;
                    r_nxt.op_all    = 1'b0;
                    r_nxt = issue(r_nxt, CPT_OP_READ_CARD, S_DN_READ);
                end
            end
            S_WAIT: begin
                if (op_done) begin
                    r_nxt.state      = r_r.after;
                    r_nxt.pend_fault = op_result;
                    if (op_result == CPT_RES_INCOMPAT) r_nxt.rejected = op_rejected_param;
                end else if (!card_present && r_r.op_code != CPT_OP_SAVE_WORKING &&
                             r_r.op_code != CPT_OP_RESTORE) begin
                    // Card pulled mid-transfer counts as missing card
                    r_nxt.state      = r_r.after;
                    r_nxt.pend_fault = CPT_RES_INVALID;
                    r_nxt.f_missing  = 1'b1;
                end
            end
            S_UP_SAVE: begin
                if (r_r.pend_fault != CPT_RES_OK) begin
                    r_nxt.f_nvm = 1'b1;
                    r_nxt.state = S_IDLE;
                end else if (!card_present) begin
                    r_nxt.f_missing = 1'b1;
                    r_nxt.state     = S_IDLE;
                end else begin
                    r_nxt = issue(r_nxt, CPT_OP_WRITE_CARD, S_UP_WRITE);
                end
            end
            S_UP_WRITE: begin
                if (r_r.pend_fault == CPT_RES_OK && !r_r.f_missing) begin
                    r_nxt.selector   = CPT_SEL_READY;
                    r_nxt.upload_req = CPT_REQ_OFF;
                end else if (!r_r.f_missing) begin
                    r_nxt.f_nvm = 1'b1;
                end
                r_nxt.state = S_IDLE;
            end
            S_DN_READ: begin
                if (r_r.f_missing) begin
                    r_nxt = issue(r_nxt, CPT_OP_RESTORE, S_DN_RESTORE);
                end else if (r_r.pend_fault == CPT_RES_OK) begin
                    r_nxt = issue(r_nxt, CPT_OP_COMMIT, S_DN_COMMIT);
                end else begin
                    case (r_r.pend_fault)
                        CPT_RES_INVALID:  r_nxt.f_invalid = 1'b1;
                        CPT_RES_INCOMPAT: begin
                            r_nxt.f_incompat = 1'b1;
                        end
                        default:          r_nxt.f_nvm = 1'b1;
                    endcase
                    r_nxt = issue(r_nxt, CPT_OP_RESTORE, S_DN_RESTORE);
                end
            end
            S_DN_COMMIT: begin
                if (r_r.pend_fault != CPT_RES_OK) begin
                    r_nxt.f_nvm = 1'b1;
                    r_nxt = issue(r_nxt, CPT_OP_RESTORE, S_DN_RESTORE);
                end else begin
                    if (r_r.is_auto) begin
                        r_nxt.auto_done = 1'b1;
                    end else begin
                        r_nxt.selector     = CPT_SEL_READY;
                        r_nxt.download_req = CPT_REQ_OFF;
                    end
                    r_nxt.state = S_IDLE;
                end
            end
            S_DN_RESTORE: begin
                r_nxt.state = S_IDLE;
            end
            default: r_nxt.state = S_IDLE;
        endcase

        // Read data registered at the setup edge
        if (rd_en) begin
            case (paddr)
                CPT_ADDR_COMMISSION:  r_nxt.prdata = {25'h0, r_r.selector};
                CPT_ADDR_UPLOAD:      r_nxt.prdata = {30'h0, r_r.upload_req};
                CPT_ADDR_DOWNLOAD:    r_nxt.prdata = {30'h0, r_r.download_req};
                CPT_ADDR_CLONE_INDEX: r_nxt.prdata = {25'h0, r_r.clone_index};
                CPT_ADDR_AUTO_POLICY: r_nxt.prdata = {30'h0, r_r.auto_policy};
                CPT_ADDR_REJECTED:    r_nxt.prdata = {16'h0, r_r.rejected};
                CPT_ADDR_STATUS:      r_nxt.prdata = status;
                default:              r_nxt.prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_r             <= '0;
            r_r.state       <= S_STARTUP;
            r_r.after       <= S_IDLE;
            r_r.op_code     <= CPT_OP_NONE;
            r_r.auto_policy <= CPT_AUTO_RESET;
        end else begin
            r_r <= r_nxt;
        end
    end

    // Access phase is one cycle; read data latched in the setup cycle
    logic rd_pending_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_pending_r <= 1'b0;
        end else begin
            rd_pending_r <= psel & ~penable & ~pwrite;
        end
    end

    assign pready  = psel & penable & (pwrite | rd_pending_r);
    assign pslverr = 1'b0;
    assign prdata  = r_r.prdata;

    // Fault state overrides everything on the lamps
    assign fault_lamp    = fault_any;
    assign ready_lamp    = ~fault_any & (r_r.is_upload && busy ? r_r.flash : ~busy);
    assign transfer_busy = busy;
    assign op_start      = r_r.op_start;
    assign op_code       = r_r.op_code;
    assign op_file       = r_r.op_file;
    assign op_all_params = r_r.op_all;
endmodule : cpt_card_transfer

// [verification/cpt_card_model.sv]
// Behavioural card and parameter store answering the controller's operations
`timescale 1ns/1ps
module cpt_card_model
    import cpt_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        op_start,
    input  wire cpt_op_t     op_code,
    input  wire cpt_op_t     fail_op,
    input  wire logic [1:0]  fail_res,
    input  wire logic [15:0] rej_param,
    input  wire logic [7:0]  dly,
    output logic             op_done,
    output logic [1:0]       op_result,
    output logic [15:0]      op_rejected_param
);
    logic [7:0] cnt_r;
    logic       run_r;
    cpt_op_t    code_r;
    logic [1:0] res;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r  <= 8'h00;
            run_r  <= 1'b0;
            code_r <= CPT_OP_NONE;
        end else if (op_start) begin
            run_r  <= 1'b1;
            cnt_r  <= dly;
            code_r <= op_code;
        end else if (run_r && cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
        end else begin
            run_r <= 1'b0;
        end
    end

    // Outside the done pulse the answer lines carry junk, never a stale result
    assign res               = (code_r == fail_op) ? fail_res : CPT_RES_OK;
    assign op_done           = run_r && cnt_r == 8'h00;
    assign op_result         = op_done ? res : ~res;
    assign op_rejected_param = op_done ? rej_param : ~rej_param;
endmodule : cpt_card_model

// [verification/cpt_card_transfer_properties.sv]
// Port-level checks of the card transfer controller
`timescale 1ns/1ps
module cpt_card_transfer_properties
    import cpt_pkg::*;
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       op_start,
    input wire cpt_op_t    op_code,
    input wire logic [6:0] op_file,
    input wire logic       op_all_params,
    input wire logic       op_done,
    input wire logic [1:0] op_result,
    input wire logic       ready_lamp,
    input wire logic       fault_lamp,
    input wire logic       transfer_busy
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Set by a save of the working set, consumed by the card write
    logic saved_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) saved_r <= 1'b0;
        else if (op_start && op_code == CPT_OP_SAVE_WORKING) saved_r <= 1'b1;
        else if (op_start && op_code == CPT_OP_WRITE_CARD) saved_r <= 1'b0;
    end

    a_lamp_fault_excl: assert property (fault_lamp |-> !ready_lamp)
        else $error("ready lamp lit with fault lamp");
    a_save_before_write: assert property (op_start && op_code == CPT_OP_WRITE_CARD |-> saved_r)
        else $error("card write without prior save");
    a_auto_file_zero: assert property (op_start && op_all_params |-> op_file == CPT_CLONE_AUTO)
        else $error("auto download not from file zero");
    a_busy_no_abort: assert property ($fell(transfer_busy) |-> $past(op_done) || $past(op_done, 2))
        else $error("transfer ended without completion");
    a_start_busy: assert property (op_start |-> transfer_busy)
        else $error("operation started while not busy");
    a_fail_restore: assert property (op_done && op_result != CPT_RES_OK && op_code == CPT_OP_READ_CARD
        |-> ##[1:3] (op_start && op_code == CPT_OP_RESTORE))
        else $error("failed read not followed by restore");
    a_fail_lamp: assert property (op_done && op_result != CPT_RES_OK |-> ##[1:3] fault_lamp)
        else $error("failure without fault lamp");
    a_done_ready: assert property (op_done && op_result == CPT_RES_OK && !op_all_params
        && (op_code == CPT_OP_WRITE_CARD || op_code == CPT_OP_COMMIT)
        |-> ##[1:3] (ready_lamp && !transfer_busy))
        else $error("success without ready lamp");
endmodule : cpt_card_transfer_properties

bind cpt_card_transfer cpt_card_transfer_properties cpt_props_i (
    .pclk(pclk), .presetn(presetn), .op_start(op_start), .op_code(op_code),
    .op_file(op_file), .op_all_params(op_all_params), .op_done(op_done),
    .op_result(op_result), .ready_lamp(ready_lamp), .fault_lamp(fault_lamp),
    .transfer_busy(transfer_busy));

// [verification/tb.sv]
// Self-checking bench for the card transfer controller
`timescale 1ns/1ps
module tb;
    import cpt_pkg::*;
    typedef struct {logic up; logic card; logic [6:0] file; cpt_op_t fop; logic [1:0] res;
                    logic [9:0] st;} cpt_row_t;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0, dly = 8'd20;
    logic [31:0] pwdata = 0, prdata;
    logic        pready, pslverr, op_start, op_all_params, op_done, ready_lamp, fault_lamp;
    logic        transfer_busy, card_present = 1, clone00_present = 1, x_all, lamp_q;
    cpt_op_t     op_code, fail_op = CPT_OP_NONE;
    logic [6:0]  op_file, x_file;
    logic [1:0]  op_result, fail_res = 0;
    logic [15:0] op_rejected_param;
    int          err_count = 0, n_tests = 0, n_ops = 0, toggles = 0, cyc = 0, k;
    cpt_row_t    r;
    logic [6:0]  sels [5] = '{7'h00, 7'h01, 7'h02, 7'h1e, 7'h5f};
    cpt_row_t    rows [8] = '{
        '{1, 1, 7'h05, CPT_OP_NONE, CPT_RES_OK, 10'h202},
        '{0, 1, 7'h63, CPT_OP_NONE, CPT_RES_OK, 10'h202},
        '{1, 1, 7'h00, CPT_OP_SAVE_WORKING, CPT_RES_NVM, 10'h244},
        '{1, 0, 7'h01, CPT_OP_NONE, CPT_RES_OK, 10'h00c},
        '{0, 1, 7'h02, CPT_OP_READ_CARD, CPT_RES_INVALID, 10'h214},
        '{0, 1, 7'h03, CPT_OP_READ_CARD, CPT_RES_INCOMPAT, 10'h224},
        '{0, 1, 7'h04, CPT_OP_COMMIT, CPT_RES_NVM, 10'h244},
        '{0, 0, 7'h04, CPT_OP_NONE, CPT_RES_OK, 10'h00c}};

    always #10 pclk = ~pclk;

    cpt_card_transfer #(.FLASH_CYCLES(4)) cpt_card_transfer_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .card_present(card_present), .clone00_present(clone00_present), .op_start(op_start),
        .op_code(op_code), .op_file(op_file), .op_all_params(op_all_params), .op_done(op_done),
        .op_result(op_result), .op_rejected_param(op_rejected_param),
        .ready_lamp(ready_lamp), .fault_lamp(fault_lamp), .transfer_busy(transfer_busy));

    cpt_card_model cpt_card_model_i (
        .pclk(pclk), .presetn(presetn), .op_start(op_start), .op_code(op_code),
        .fail_op(fail_op), .fail_res(fail_res), .rej_param(16'h0123), .dly(dly),
        .op_done(op_done), .op_result(op_result), .op_rejected_param(op_rejected_param));

    always @(posedge pclk) begin
        if (op_start === 1'b1) begin
            n_ops++;
            if (op_code == CPT_OP_READ_CARD || op_code == CPT_OP_WRITE_CARD) begin
                x_file = op_file;
                x_all  = op_all_params;
            end
        end
        if (transfer_busy === 1'b1 && ready_lamp !== lamp_q) toggles++;
        lamp_q = ready_lamp;
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Read data is taken at the handshake edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) err_count++;
        rd = prdata;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        apb(1'b1, a, d, x);
    endtask : wr

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
        logic [31:0] d;
        apb(1'b0, a, 32'h0, d);
        chk(nm, d & m, exp);
    endtask : rdchk

    task automatic wait_idle();
        int n;
        n = 0;
        while (transfer_busy !== 1'b0 && n < 500) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 500) err_count++;
    endtask : wait_idle

    task automatic stop_test();
        $display("comparisons %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        wait_idle();
        chk("auto op", 32'({x_all, x_file}), 32'({1'b1, CPT_CLONE_AUTO}));
        rdchk("auto msg", CPT_ADDR_STATUS, 32'h100, 32'h100);
        rdchk("policy", CPT_ADDR_AUTO_POLICY, '1, 32'h0);
        wr(CPT_ADDR_CLEAR, 32'h100);
        rdchk("msg clear", CPT_ADDR_STATUS, 32'h100, 32'h0);
        card_present <= 1'b0;
        repeat (3) @(posedge pclk);
        card_present <= 1'b1;
        rdchk("alarm", CPT_ADDR_STATUS, 32'h80, 32'h80);
        wr(CPT_ADDR_CLEAR, 32'h80);
        rdchk("alarm ack", CPT_ADDR_STATUS, 32'h80, 32'h0);
        foreach (rows[i]) begin
            r = rows[i];
            card_present <= r.card;
            fail_op      <= r.fop;
            fail_res     <= r.res;
            wr(CPT_ADDR_UPLOAD, 32'h0);
            wr(CPT_ADDR_DOWNLOAD, 32'h0);
            wr(CPT_ADDR_CLEAR, 32'h1f8);
            wr(CPT_ADDR_COMMISSION, 32'h1e);
            wr(CPT_ADDR_CLONE_INDEX, 32'(r.file));
            toggles = 0;
            wr(r.up ? CPT_ADDR_UPLOAD : CPT_ADDR_DOWNLOAD, 32'h2);
            repeat (2) @(posedge pclk);
            if (transfer_busy === 1'b1) begin
                wr(r.up ? CPT_ADDR_DOWNLOAD : CPT_ADDR_UPLOAD, 32'h2);
                wr(CPT_ADDR_CLONE_INDEX, 32'(r.file + 7'h01));
            end
            wait_idle();
            rdchk("status", CPT_ADDR_STATUS, 32'h37f, 32'(r.st));
            rdchk("clone", CPT_ADDR_CLONE_INDEX, '1, 32'(r.file));
            if (r.up && r.card && r.fop == CPT_OP_NONE) chk("flash", 32'(toggles > 1), 32'h1);
            if (r.res == CPT_RES_INCOMPAT) rdchk("rejected", CPT_ADDR_REJECTED, '1, 32'h123);
            if (r.st == 10'h202) begin
                chk("file", 32'({x_all, x_file}), 32'(r.file));
                rdchk("sel done", CPT_ADDR_COMMISSION, '1, 32'h0);
                rdchk("up done", CPT_ADDR_UPLOAD, '1, 32'h0);
                rdchk("down done", CPT_ADDR_DOWNLOAD, '1, 32'h0);
            end
        end
        foreach (sels[i]) begin
            wr(CPT_ADDR_COMMISSION, 32'(sels[i]));
            rdchk("selector", CPT_ADDR_COMMISSION, '1, 32'(sels[i]));
        end
        wr(CPT_ADDR_COMMISSION, 32'h07);
        rdchk("sel bad", CPT_ADDR_COMMISSION, '1, 32'h5f);
        wr(CPT_ADDR_CLONE_INDEX, 32'h63);
        wr(CPT_ADDR_CLONE_INDEX, 32'h64);
        rdchk("clone max", CPT_ADDR_CLONE_INDEX, '1, 32'h63);
        wr(CPT_ADDR_COMMISSION, 32'h1e);
        k = n_ops;
        wr(CPT_ADDR_UPLOAD, 32'h1);
        wr(CPT_ADDR_DOWNLOAD, 32'h1);
        wr(CPT_ADDR_CLEAR, 32'h1f8);
        repeat (8) @(posedge pclk);
        chk("panel ops", 32'(n_ops - k), 32'h0);
        rdchk("panel up", CPT_ADDR_UPLOAD, '1, 32'h1);
        rdchk("unmapped", 8'h20, '1, 32'h0);
        wr(CPT_ADDR_AUTO_POLICY, 32'h2);
        rdchk("policy 2", CPT_ADDR_AUTO_POLICY, '1, 32'h2);
        clone00_present <= 1'b0;
        presetn         <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        k = n_ops;
        repeat (8) @(posedge pclk);
        chk("auto skip", 32'(n_ops - k), 32'h0);
        rdchk("sel reset", CPT_ADDR_COMMISSION, '1, 32'h0);
        rdchk("policy reset", CPT_ADDR_AUTO_POLICY, '1, 32'(CPT_AUTO_RESET));
        stop_test();
    end
endmodule : tb
